// >>> logic/touch_pkg.sv
// Shared constants and types for the touch screen converter control block
`default_nettype none
package touch_pkg;
  // System clock and converter clock rates
  localparam int CLK_HZ     = 25_000_000;
  localparam int CONV_HZ_8  = 4_000_000;  // 8-bit converter clock
  localparam int CONV_HZ_12 = 2_000_000;  // 12-bit converter clock
  // Cycles per converter bit, rounded up so the rate never exceeds the target
  localparam int DIV_8_CYC  = (CLK_HZ + CONV_HZ_8 - 1) / CONV_HZ_8;
  localparam int DIV_12_CYC = (CLK_HZ + CONV_HZ_12 - 1) / CONV_HZ_12;
  localparam logic [3:0] DIV_8_LAST  = 4'(DIV_8_CYC - 1);
  localparam logic [3:0] DIV_12_LAST = 4'(DIV_12_CYC - 1);

  // Trial bit positions; the code is kept left aligned in 12 bits
  localparam logic [3:0] BIT_MSB    = 4'hb;
  localparam logic [3:0] BIT_LSB_12 = 4'h0;
  localparam logic [3:0] BIT_LSB_8  = 4'h4;

  // Filter sample counts
  localparam int         FILT_SAMPLES   = 7;
  localparam logic [2:0] SAMP_LAST_FILT = 3'h6;
  localparam logic [2:0] SAMP_LAST_BYP  = 3'h0;
  localparam logic [2:0] RANK_LO        = 3'h2;  // First of middle three
  localparam logic [2:0] RANK_HI        = 3'h4;  // Last of middle three

  // Command function codes
  localparam logic [3:0] FN_DIODE_SENSE_SINGLE   = 4'h0;
  localparam logic [3:0] FN_AUX     = 4'h2;
  localparam logic [3:0] FN_DIODE_SENSE_RATIO   = 4'h4;
  localparam logic [3:0] FN_DRV_X   = 4'h8;
  localparam logic [3:0] FN_DRV_Y   = 4'h9;
  localparam logic [3:0] FN_DRV_YX  = 4'ha;
  localparam logic [3:0] FN_SETUP   = 4'hb;
  localparam logic [3:0] FN_MEAS_X  = 4'hc;
  localparam logic [3:0] FN_MEAS_Y  = 4'hd;
  localparam logic [3:0] FN_MEAS_Z1 = 4'he;
  localparam logic [3:0] FN_MEAS_Z2 = 4'hf;

  // Setup data bit positions
  localparam int SETUP_PULLUP_BIT = 0;
  localparam int SETUP_BYPASS_BIT = 1;

  // Values after reset
  localparam logic PULLUP_90K_RST = 1'b0;  // 50 kilohm pull-up
  localparam logic BYPASS_RST     = 1'b0;  // Filter in use
  localparam logic PEN_EN_RST     = 1'b1;  // Pen detect armed

  // Decoded command from the serial slave
  typedef struct packed {
    logic [3:0] func;
    logic       res_8bit;
    logic       pen_detect_off_bit;
    logic [3:0] setup_data;
  } cmd_t;

  // Panel driver switches
  typedef struct packed {
    logic xp;
    logic xm;
    logic yp;
    logic ym;
  } drv_t;

  // Converter reference pair
  typedef enum logic [1:0] {
    REF_SUPPLY  = 2'h0,
    REF_Y_PLATE = 2'h1,
    REF_X_PLATE = 2'h2,
    REF_YP_XM   = 2'h3
  } ref_sel_t;

  // Converter input channel
  typedef enum logic [2:0] {
    IN_XP    = 3'h0,
    IN_YP    = 3'h1,
    IN_YM    = 3'h2,
    IN_DIODE_SENSE_SINGLE = 3'h3,
    IN_DIODE_SENSE_RATIO = 3'h4,
    IN_AUX   = 3'h5
  } mux_sel_t;

  // Panel setup for one command
  typedef struct packed {
    drv_t     drv;
    mux_sel_t mux;
    ref_sel_t refs;
    logic     measure;
    logic     drive_only;
  } panel_cfg_t;

  // Conversion result
  typedef struct packed {
    logic [11:0] code;
    logic        res_8bit;
  } result_t;

  // Sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_FILT = 2'b11,
    ST_DONE = 2'b10
  } conv_state_t;
endpackage
`default_nettype wire

// >>> logic/conv_rate_divider.sv
// Converter bit clock enable divider
`default_nettype none
module conv_rate_divider (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_restart,
  input  wire logic i_res_8bit,
  output logic      o_tick
);
  logic [3:0] cnt_r;   // Cycles in current bit
  logic [3:0] last;    // Terminal count

  // Faster rate for 8-bit, slower for 12-bit
  assign last = i_res_8bit ? touch_pkg::DIV_8_LAST : touch_pkg::DIV_12_LAST;

  // Counter and one-cycle tick
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_r  <= 4'h0;
      o_tick <= 1'b0;
    end
    else if (i_restart)
    begin
      cnt_r  <= 4'h0;
      o_tick <= 1'b0;
    end
    else if (cnt_r >= last)
    begin
      cnt_r  <= 4'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 4'h1;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> logic/median_mean_filter.sv
// Seven-sample median filter averaging the middle three
`default_nettype none
module median_mean_filter (
  input  wire logic [6:0][11:0] i_samples,
  output logic      [11:0]      o_mean
);
  logic [6:0][2:0] rank;      // Sorted position of each sample
  logic [13:0]     sum_mid;   // Sum of middle three

  // Rank each sample; ties broken by index so ranks are unique
  generate
    for (genvar i = 0; i < touch_pkg::FILT_SAMPLES; i++)
    begin : g_rank
      always_comb
      begin
        rank[i] = 3'h0;
        for (int j = 0; j < touch_pkg::FILT_SAMPLES; j++)
        begin
          if ((i_samples[j] < i_samples[i]) ||
              ((i_samples[j] == i_samples[i]) && (j < i)))
          begin
            rank[i] = rank[i] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // Sum samples whose rank is in the middle three
  always_comb
  begin
    sum_mid = 14'h0;
    for (int k = 0; k < touch_pkg::FILT_SAMPLES; k++)
    begin
      if (rank[k] >= touch_pkg::RANK_LO && rank[k] <= touch_pkg::RANK_HI)
      begin
        sum_mid = sum_mid + {2'h0, i_samples[k]};
      end
    end
  end

  // Truncating divide by three
  assign o_mean = 12'(sum_mid / 14'h3);
endmodule
`default_nettype wire

// >>> logic/touch_adc_pen_detect_filter.sv
// Touch screen converter control: panel drivers, SAR sequencing, pen detect
`default_nettype none
module touch_adc_pen_detect_filter (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_addr_write_ack,
  input  wire logic                  i_cmd_valid,
  input  wire touch_pkg::cmd_t       i_cmd,
  input  wire logic                  i_xfer_end,
  input  wire logic                  i_cmp,
  input  wire logic                  i_xplus_low,
  output touch_pkg::drv_t            o_drv,
  output touch_pkg::mux_sel_t        o_mux_sel,
  output touch_pkg::ref_sel_t        o_ref_sel,
  output logic                       o_xplus_pen_connect,
  output logic [11:0]                o_dac_trial,
  output logic                       o_busy,
  output touch_pkg::result_t         o_result,
  output logic                       o_result_valid,
  output logic                       o_pullup_90k,
  output logic                       o_filter_bypass,
  output logic                       o_pen_touch_request_n
);
  // Synchronisers for comparator and pen sense
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic pen_meta_r;
  logic pen_sync_r;

  // Command holding
  touch_pkg::cmd_t     cmd_pend_r;   // Received, awaiting end of transfer
  logic                cmd_have_r;   // A command is pending
  touch_pkg::cmd_t     cmd_act_r;    // Command now in effect
  touch_pkg::panel_cfg_t cfg_act_r;  // Panel setup of active command
  touch_pkg::panel_cfg_t cfg_nxt;    // Decoded setup of pending command
  logic                launch;       // Pending command takes effect

  // Setup and pen state
  logic pullup_90k_r;   // Pull-up select
  logic bypass_r;       // Filter bypass
  logic drive_only_r;   // Drivers on without conversion
  logic pen_en_r;       // Pen interrupt function armed

  // Sequencer
  touch_pkg::conv_state_t state_r;
  logic [11:0]       sar_r;        // Left-aligned trial code
  logic [11:0]       kept;         // Trial after comparator decision
  logic [3:0]        bit_idx_r;    // Bit under trial
  logic [3:0]        bit_lsb;      // Last trial bit for resolution
  logic [2:0]        samp_idx_r;   // Sample being converted
  logic [2:0]        samp_last;    // Last sample index
  logic [6:0][11:0]  samples_r;    // Captured samples
  logic [11:0]       filt_mean;    // Filter output
  logic [11:0]       single_code;  // Unfiltered sample, right-justified
  logic              tick;         // Converter bit enable

  // Map a function code to panel switches, input and reference
  function automatic touch_pkg::panel_cfg_t decode_cfg(input logic [3:0] func);
    touch_pkg::panel_cfg_t c;
    c            = '0;
    c.mux        = touch_pkg::IN_XP;
    c.refs       = touch_pkg::REF_SUPPLY;
    case (func)
      touch_pkg::FN_MEAS_X:
      begin
        c.drv     = '{xp: 1'b1, xm: 1'b1, yp: 1'b0, ym: 1'b0};
        c.mux     = touch_pkg::IN_YP;
        c.refs    = touch_pkg::REF_X_PLATE;
        c.measure = 1'b1;
      end
      touch_pkg::FN_MEAS_Y:
      begin
        c.drv     = '{xp: 1'b0, xm: 1'b0, yp: 1'b1, ym: 1'b1};
        c.refs    = touch_pkg::REF_Y_PLATE;
        c.measure = 1'b1;
      end
      touch_pkg::FN_MEAS_Z1:
      begin
        c.drv     = '{xp: 1'b0, xm: 1'b1, yp: 1'b1, ym: 1'b0};
        c.refs    = touch_pkg::REF_YP_XM;
        c.measure = 1'b1;
      end
      touch_pkg::FN_MEAS_Z2:
      begin
        c.drv     = '{xp: 1'b0, xm: 1'b1, yp: 1'b1, ym: 1'b0};
        c.mux     = touch_pkg::IN_YM;
        c.refs    = touch_pkg::REF_YP_XM;
        c.measure = 1'b1;
      end
      touch_pkg::FN_DIODE_SENSE_SINGLE:
      begin
        c.mux     = touch_pkg::IN_DIODE_SENSE_SINGLE;
        c.measure = 1'b1;
      end
      touch_pkg::FN_DIODE_SENSE_RATIO:
      begin
        c.mux     = touch_pkg::IN_DIODE_SENSE_RATIO;
        c.measure = 1'b1;
      end
      touch_pkg::FN_AUX:
      begin
        c.mux     = touch_pkg::IN_AUX;
        c.measure = 1'b1;
      end
      touch_pkg::FN_DRV_X:
      begin
        c.drv        = '{xp: 1'b1, xm: 1'b1, yp: 1'b0, ym: 1'b0};
        c.drive_only = 1'b1;
      end
      touch_pkg::FN_DRV_Y:
      begin
        c.drv        = '{xp: 1'b0, xm: 1'b0, yp: 1'b1, ym: 1'b1};
        c.drive_only = 1'b1;
      end
      touch_pkg::FN_DRV_YX:
      begin
        c.drv        = '{xp: 1'b0, xm: 1'b1, yp: 1'b1, ym: 1'b0};
        c.drive_only = 1'b1;
      end
      default:
      begin
        c.measure = 1'b0;  // Setup and unused codes drive nothing
      end
    endcase
    return c;
  endfunction

  // Pending command acts on STOP or repeated START
  assign launch  = i_xfer_end && cmd_have_r;
  assign cfg_nxt = decode_cfg(cmd_pend_r.func);

  // Resolution and bypass dependent limits
  assign bit_lsb   = cmd_act_r.res_8bit ? touch_pkg::BIT_LSB_8
                                        : touch_pkg::BIT_LSB_12;
  assign samp_last = bypass_r ? touch_pkg::SAMP_LAST_BYP
                              : touch_pkg::SAMP_LAST_FILT;

  // Keep trial bit if input is at or above trial level
  assign kept = cmp_sync_r ? sar_r : (sar_r & ~(12'h1 << bit_idx_r));

  // Right-justified code of the first sample, for bypass
  assign single_code = cmd_act_r.res_8bit ? {4'h0, samples_r[0][11:4]}
                                          : samples_r[0];

  // Converter bit rate enable
  conv_rate_divider u_div (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_restart  (launch),
    .i_res_8bit (cmd_act_r.res_8bit),
    .o_tick     (tick)
  );

  // Median and mean of seven samples, same path for every input
  median_mean_filter u_filt (
    .i_samples (samples_r),
    .o_mean    (filt_mean)
  );

  // Two-stage synchronisers for comparator and pen sense
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
      pen_meta_r <= 1'b0;
      pen_sync_r <= 1'b0;
    end
    else
    begin
      cmp_meta_r <= i_cmp;
      cmp_sync_r <= cmp_meta_r;
      pen_meta_r <= i_xplus_low;
      pen_sync_r <= pen_meta_r;
    end
  end

  // Command capture from the slave port; nothing here drives the bus
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmd_pend_r <= '0;
      cmd_have_r <= 1'b0;
      cmd_act_r  <= '0;
      cfg_act_r  <= '0;
    end
    else
    begin
      if (i_cmd_valid)
      begin
        cmd_pend_r <= i_cmd;
        cmd_have_r <= 1'b1;
      end
      else if (launch)
      begin
        cmd_have_r <= 1'b0;
      end
      if (launch && cmd_pend_r.func != touch_pkg::FN_SETUP)
      begin
        cmd_act_r <= cmd_pend_r;
        cfg_act_r <= cfg_nxt;
      end
      else if (launch)
      begin
        cmd_act_r.pen_detect_off_bit <= cmd_pend_r.pen_detect_off_bit;
      end
    end
  end

  // Setup command: pull-up select and filter bypass
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pullup_90k_r <= touch_pkg::PULLUP_90K_RST;
      bypass_r     <= touch_pkg::BYPASS_RST;
    end
    else if (launch && cmd_pend_r.func == touch_pkg::FN_SETUP)
    begin
      // Select sits in the lowest data bit
      pullup_90k_r <= cmd_pend_r.setup_data[touch_pkg::SETUP_PULLUP_BIT];
      bypass_r     <= cmd_pend_r.setup_data[touch_pkg::SETUP_BYPASS_BIT];
    end
  end

  // Driver-only mode holds until the next non-setup command takes effect
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      drive_only_r <= 1'b0;
    end
    else if (launch && cmd_pend_r.func != touch_pkg::FN_SETUP)
    begin
      drive_only_r <= cfg_nxt.drive_only;
    end
  end

  // Pen interrupt arming
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pen_en_r <= touch_pkg::PEN_EN_RST;
    end
    else if (i_addr_write_ack)
    begin
      pen_en_r <= 1'b0;
    end
    else if (launch && cfg_nxt.drive_only &&
             cmd_pend_r.func != touch_pkg::FN_SETUP)
    begin
      pen_en_r <= 1'b0;
    end
    else if (launch && cmd_pend_r.func == touch_pkg::FN_SETUP)
    begin
      // Setup has no conversion; arm at once unless detect is off
      pen_en_r <= !cmd_pend_r.pen_detect_off_bit;
    end
    else if (state_r == touch_pkg::ST_DONE)
    begin
      pen_en_r <= !cmd_act_r.pen_detect_off_bit;
    end
  end

  // Conversion sequencer and successive approximation
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r    <= touch_pkg::ST_IDLE;
      sar_r      <= 12'h0;
      bit_idx_r  <= touch_pkg::BIT_MSB;
      samp_idx_r <= 3'h0;
      samples_r  <= '0;
    end
    else if (launch)
    begin
      // New measure command restarts; anything else idles
      state_r    <= (cmd_pend_r.func != touch_pkg::FN_SETUP && cfg_nxt.measure)
                    ? touch_pkg::ST_CONV : touch_pkg::ST_IDLE;
      sar_r      <= 12'h1 << touch_pkg::BIT_MSB;
      bit_idx_r  <= touch_pkg::BIT_MSB;
      samp_idx_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        touch_pkg::ST_IDLE:
        begin
          state_r <= touch_pkg::ST_IDLE;
        end
        touch_pkg::ST_CONV:
        begin
          if (tick)
          begin
            if (bit_idx_r == bit_lsb)
            begin
              // Sample finished; straight binary code kept
              samples_r[samp_idx_r] <= kept;
              sar_r                 <= 12'h1 << touch_pkg::BIT_MSB;
              bit_idx_r             <= touch_pkg::BIT_MSB;
              if (samp_idx_r == samp_last)
              begin
                state_r <= touch_pkg::ST_FILT;
              end
              else
              begin
                samp_idx_r <= samp_idx_r + 3'h1;
              end
            end
            else
            begin
              // Decide this bit, try the next lower one
              sar_r     <= kept | (12'h1 << (bit_idx_r - 4'h1));
              bit_idx_r <= bit_idx_r - 4'h1;
            end
          end
        end
        touch_pkg::ST_FILT:
        begin
          state_r <= touch_pkg::ST_DONE;
        end
        touch_pkg::ST_DONE:
        begin
          state_r <= touch_pkg::ST_IDLE;
        end
        default:
        begin
          state_r <= touch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result register, filtered or single sample
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_result       <= '0;
      o_result_valid <= 1'b0;
    end
    else
    begin
      o_result_valid <= (state_r == touch_pkg::ST_DONE);
      if (state_r == touch_pkg::ST_FILT)
      begin
        o_result.res_8bit <= cmd_act_r.res_8bit;
        if (bypass_r)
        begin
          o_result.code <= single_code;
        end
        else if (cmd_act_r.res_8bit)
        begin
          o_result.code <= {4'h0, filt_mean[11:4]};
        end
        else
        begin
          o_result.code <= filt_mean;
        end
      end
    end
  end

  // Panel switches, input select and pen path
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_drv               <= '{xp: 1'b0, xm: 1'b0, yp: 1'b0, ym: 1'b1};
      o_mux_sel           <= touch_pkg::IN_XP;
      o_ref_sel           <= touch_pkg::REF_SUPPLY;
      o_xplus_pen_connect <= 1'b0;
      o_dac_trial         <= 12'h0;
      o_busy              <= 1'b0;
    end
    else
    begin
      o_dac_trial <= sar_r;
      o_busy      <= (state_r != touch_pkg::ST_IDLE);
      o_mux_sel   <= cfg_act_r.mux;
      o_ref_sel   <= cfg_act_r.refs;
      if (state_r == touch_pkg::ST_CONV || drive_only_r)
      begin
        // Measuring or settling: X+ off the pen path
        o_drv               <= cfg_act_r.drv;
        o_xplus_pen_connect <= 1'b0;
      end
      else if (!cmd_act_r.pen_detect_off_bit && pen_en_r)
      begin
        // Powered down and armed: Y- grounded, X+ sensed
        o_drv               <= '{xp: 1'b0, xm: 1'b0, yp: 1'b0, ym: 1'b1};
        o_xplus_pen_connect <= 1'b1;
      end
      else
      begin
        o_drv               <= '0;
        o_xplus_pen_connect <= 1'b0;
      end
    end
  end

  // Pen request output and setup bits
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pen_touch_request_n <= 1'b1;
      o_pullup_90k          <= touch_pkg::PULLUP_90K_RST;
      o_filter_bypass       <= touch_pkg::BYPASS_RST;
    end
    else
    begin
      o_pullup_90k    <= pullup_90k_r;
      o_filter_bypass <= bypass_r;
      if (drive_only_r)
      begin
        o_pen_touch_request_n <= 1'b0;
      end
      else
      begin
        o_pen_touch_request_n <= !(o_xplus_pen_connect && pen_sync_r);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/touch_host_model.sv
// Host model driving serial write transfers into the block
`default_nettype none
module touch_host_model (
  input  wire logic       i_clk,
  output logic            o_addr_write_ack,
  output logic            o_cmd_valid,
  output touch_pkg::cmd_t o_cmd,
  output logic            o_xfer_end,
  output logic            o_pen_masked
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at start
  initial {o_addr_write_ack, o_cmd_valid, o_cmd, o_xfer_end, o_pen_masked} = '0;
  // Address ack, command byte, optional stall, then stop
  task automatic write(input touch_pkg::cmd_t cmd, input int gap);
    o_pen_masked = 1'b1;
    @(negedge i_clk) o_addr_write_ack = 1'b1;
    @(negedge i_clk) o_addr_write_ack = 1'b0;
    o_cmd_valid = 1'b1;
    o_cmd = cmd;
    @(negedge i_clk) o_cmd_valid = 1'b0;
    o_cmd = ~cmd;
    repeat (gap) @(negedge i_clk);
    o_xfer_end = 1'b1;
    @(negedge i_clk) o_xfer_end = 1'b0;
    o_pen_masked = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/touch_monitor.sv
// Port checker for the touch converter control block
`default_nettype none
module touch_monitor (
  input wire logic               i_clk,
  input wire logic               i_reset,
  input wire logic               i_addr_write_ack,
  input wire logic               i_cmd_valid,
  input wire touch_pkg::cmd_t    i_cmd,
  input wire logic               i_xfer_end,
  input wire logic               i_xplus_low,
  input wire touch_pkg::drv_t    o_drv,
  input wire logic               o_xplus_pen_connect,
  input wire logic               o_busy,
  input wire touch_pkg::result_t o_result,
  input wire logic               o_result_valid,
  input wire logic               o_pullup_90k,
  input wire logic               o_pen_touch_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Setup write with pull-up bit b
  sequence setup_s(b);
    i_cmd_valid && i_cmd.func == touch_pkg::FN_SETUP && i_cmd.setup_data[0] == b
    ##1 i_xfer_end;
  endsequence
  // Driver-only write
  sequence drv_s;
    i_cmd_valid && i_cmd.func inside {[4'h8:4'ha]} ##1 i_xfer_end;
  endsequence
  pull_up_a: assert property (setup_s(1'b1) |-> ##[1:3] o_pullup_90k)
    else $error("pull-up not raised");
  pull_down_a: assert property (setup_s(1'b0) |-> ##[1:3] !o_pullup_90k)
    else $error("pull-up not restored");
  drv_idle_a: assert property (drv_s |=> !o_busy [*6])
    else $error("driver write converted");
  drv_force_a: assert property (drv_s |-> ##[1:4] !o_pen_touch_request_n)
    else $error("pen request not forced");
  ack_off_a: assert property (i_addr_write_ack |-> ##[1:3] !o_xplus_pen_connect)
    else $error("pen path kept");
  touch_low_a: assert property (
    (i_xplus_low && o_xplus_pen_connect) [*4] |=> !o_pen_touch_request_n)
    else $error("touch not signalled");
  meas_off_a: assert property (
    $rose(o_busy) && (o_drv.xp || o_drv.yp) |-> !o_xplus_pen_connect)
    else $error("pen path on in measurement");
  byte_fit_a: assert property (
    o_result_valid && o_result.res_8bit |-> o_result.code[11:8] == 4'h0)
    else $error("8-bit result too wide");
endmodule
bind touch_adc_pen_detect_filter touch_monitor i_mon (.*);
`default_nettype wire

// >>> verification/touch_adc_pen_detect_filter_test.sv
// Self-checking bench for the touch converter control block
`default_nettype none
module touch_adc_pen_detect_filter_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Rows: function, 8-bit, bypass, expected input select, expected reference, input level
  localparam logic [22:0] ROWS [7] = '{{4'hc, 2'h1, 3'h1, 2'h2, 12'ha5c},
    {4'hd, 2'h3, 3'h0, 2'h1, 12'h3c7}, {4'he, 2'h0, 3'h0, 2'h3, 12'h7f1},
    {4'hf, 2'h2, 3'h2, 2'h3, 12'h0e2}, {4'h0, 2'h1, 3'h3, 2'h0, 12'h5a5},
    {4'h2, 2'h2, 3'h5, 2'h0, 12'hffe}, {4'h4, 2'h0, 3'h4, 2'h0, 12'h001}};
  // Filter samples; sorted middle three average to 040
  localparam logic [11:0] SAMP [7] = '{12'h070, 12'h010, 12'h051, 12'h020, 12'h041,
    12'h061, 12'h030};
  logic               i_clk = 1'b0;
  logic               i_reset, i_addr_write_ack, i_cmd_valid, i_xfer_end, i_cmp;
  logic               i_xplus_low, seq, o_xplus_pen_connect, o_busy, o_result_valid;
  logic               o_pullup_90k, o_filter_bypass, o_pen_touch_request_n;
  touch_pkg::cmd_t    i_cmd;
  touch_pkg::drv_t    o_drv;
  touch_pkg::result_t o_result;
  touch_pkg::mux_sel_t o_mux_sel;
  touch_pkg::ref_sel_t o_ref_sel;
  logic [11:0]        o_dac_trial, vin, last;
  int                 error_cnt = 0, num_checks = 0, k = 0, n, ov;
  touch_host_model i_host (.i_clk(i_clk), .o_addr_write_ack(i_addr_write_ack),
    .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_xfer_end(i_xfer_end), .o_pen_masked());
  touch_adc_pen_detect_filter i_dut (.*);
  always #20 i_clk = ~i_clk;
  // Comparator; in the filter case a new sample starts at each fresh top trial
  always @(negedge i_clk)
  begin
    // First sample loads at once, since the idle trial already sits at the top
    if (seq && k < touch_pkg::FILT_SAMPLES && o_dac_trial == 12'h800 &&
        (last != 12'h800 || k == 0))
    begin
      vin = SAMP[k];
      k++;
    end
    last = o_dac_trial;
    i_cmp = vin >= o_dac_trial;
  end
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Write a command, then wait up to lim cycles for a result
  task automatic send(input logic [9:0] c, input int lim, input int gap = 0);
    i_host.write(c, gap);
    n = 0;
    while (o_result_valid !== 1'b1 && n < lim)
    begin
      @(negedge i_clk);
      n++;
    end
    // A conversion that never reports counts as a mismatch
    if (lim > 8)
      check("valid", o_result_valid, 1);
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    logic [22:0] r;
    {i_reset, i_xplus_low, seq, i_cmp} = 4'h8;
    vin = '0;
    last = '0;
    repeat (8) @(posedge i_clk);
    check("pen", o_pen_touch_request_n, 1);
    check("pullup", o_pullup_90k, 0);
    @(negedge i_clk) i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    check("drv", o_drv, 4'h1);
    check("connect", o_xplus_pen_connect, 1);
    i_xplus_low = 1'b1;
    repeat (5) @(negedge i_clk);
    check("pen", o_pen_touch_request_n, 0);
    i_xplus_low = 1'b0;
    // Every input, both resolutions, filter on and off
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      send({4'hb, 4'h0, r[17], 1'b0}, 2);
      vin = r[11:0];
      send({r[22:18], 5'h00}, 3000);
      check("code", o_result.code, r[18] ? {4'h0, r[11:4]} : r[11:0]);
      check("res8", o_result.res_8bit, r[18]);
      check("bypass", o_filter_bypass, r[17]);
      check("mux", o_mux_sel, r[16:14]);
      check("ref", o_ref_sel, r[13:12]);
      // Three cycles from launch to result: tick phase, filter, done
      ov = n - (r[17] ? 1 : 7) * (r[18] ? 8 * touch_pkg::DIV_8_CYC : 12 * touch_pkg::DIV_12_CYC);
      check("overhead", ov, 3);
      repeat (4) @(negedge i_clk);
      check("connect", o_xplus_pen_connect, 1);
    end
    // Seven scattered samples through the filter
    send({4'hb, 6'h00}, 2);
    seq = 1'b1;
    send({4'hc, 6'h00}, 3000);
    check("filtered", o_result.code, 12'h040);
    seq = 1'b0;
    // Pen detect off from a slow host, then back on by setup
    send({4'hd, 2'h1, 4'h0}, 3000, 3);
    i_xplus_low = 1'b1;
    repeat (6) @(negedge i_clk);
    check("pen", o_pen_touch_request_n, 1);
    send({4'hb, 6'h00}, 6);
    check("pen", o_pen_touch_request_n, 0);
    i_xplus_low = 1'b0;
    send({4'hb, 6'h01}, 2);
    check("pullup", o_pullup_90k, 1);
    send({4'hb, 6'h00}, 2);
    check("pullup", o_pullup_90k, 0);
    // Driver-only commands
    for (int f = 8; f < 11; f++)
    begin
      send({4'(f), 6'h00}, 4);
      check("busy", o_busy, 0);
      check("pen", o_pen_touch_request_n, 0);
      check("drv", o_drv, f == 8 ? 4'hc : f == 9 ? 4'h3 : 4'h6);
    end
    wrap_up();
  end
  // Watchdog far beyond the expected run
  initial
  begin
    #2_000_000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
